// ==== hdl/apc_power_ctrl.sv ====
// Power, reference and result sequencing of the converter with a Wishbone slave.
//
// Local design decisions: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_power_ctrl #(
  parameter int IREF_WAKE_CYC = `APC_IREF_WAKE_MS * (`APC_CLK_HZ / 1000)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic addr_ok_i,
  input wire logic stop_i,
  input wire logic nack_i,
  input wire logic rstart_i,
  input wire logic conv_done_i,
  input wire logic [`APC_RES_W-1:0] conv_data_i,
  output logic conv_start_o,
  output logic conv_chan_o,
  output logic conv_diff_o,
  output logic conv_clk_bus_o,
  output logic stretch_o,
  output logic analog_pwr_o,
  output logic iref_pwr_o,
  output logic iref_ready_o,
  output logic ref_drive_o,
  output logic ref_ext_o,
  output logic [1:0] ref_src_o
);
  apc_pkg::apc_state_type state;
  apc_pkg::apc_state_type next_state;
  logic [7:0] setup;
  logic [7:0] next_setup;
  logic [7:0] config_reg;
  logic [7:0] next_config_reg;
  logic [3:0] conv_left;
  logic [3:0] next_conv_left;
  logic [3:0] res_cnt;
  logic [3:0] next_res_cnt;
  logic [`APC_MEM_AW-1:0] wr_ptr;
  logic [`APC_MEM_AW-1:0] next_wr_ptr;
  logic [`APC_MEM_AW-1:0] rd_ptr;
  logic [`APC_MEM_AW-1:0] next_rd_ptr;
  logic res_valid;
  logic next_res_valid;
  logic chan;
  logic next_chan;
  logic [17:0] iref_cnt;
  logic [17:0] next_iref_cnt;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic next_conv_start_o;
  logic next_iref_pwr_o;
  logic mem_we;
  logic [`APC_RES_W-1:0] mem_wdata;
  logic [`APC_RES_W-1:0] mem_rdata;
  logic req;
  logic end_evt;
  logic [2:0] sel;
  logic clk_bus;
  logic bip;
  logic cs0;
  logic [1:0] scan;

  assign sel = setup[`APC_SETUP_SEL_LSB +: 3];
  assign clk_bus = setup[`APC_SETUP_CLK_BIT];
  assign bip = setup[`APC_SETUP_BIP_BIT];
  assign cs0 = config_reg[`APC_CFG_CS0_BIT];
  assign scan = config_reg[`APC_CFG_SCAN_LSB +: 2];
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign end_evt = stop_i || nack_i || rstart_i;

  // Output coding of one raw offset-binary result.
  function automatic logic [`APC_RES_W-1:0] code_result(input logic [`APC_RES_W-1:0] raw,
                                                        input logic bipolar);
    code_result = bipolar ? {~raw[`APC_RES_W-1], raw[`APC_RES_W-2:0]} : raw;
  endfunction

  // Number of conversions of one internal-clock scan.
  function automatic logic [3:0] scan_count(input logic [1:0] mode, input logic last);
    if (mode == `APC_SCAN_UP) begin
      scan_count = last ? 4'h2 : `APC_SINGLE_COUNT;
    end else if (mode == `APC_SCAN_EIGHT) begin
      scan_count = `APC_EIGHT_COUNT;
    end else begin
      scan_count = `APC_SINGLE_COUNT;
    end
  endfunction

  // Channel of the next conversion; only the upward scan moves.
  function automatic logic chan_step(input logic [1:0] mode, input logic cur, input logic last);
    if (mode == `APC_SCAN_UP) begin
      chan_step = (cur == last) ? 1'b0 : 1'b1;
    end else begin
      chan_step = last;
    end
  endfunction

  // Read pointer that wraps back to the first stored result.
  function automatic logic [`APC_MEM_AW-1:0] rd_step(input logic [`APC_MEM_AW-1:0] ptr,
                                                     input logic [3:0] cnt);
    if ({1'b0, ptr} + 4'h1 >= cnt) begin
      rd_step = '0;
    end else begin
      rd_step = ptr + 1'b1;
    end
  endfunction

  assign mem_wdata = code_result(conv_data_i, bip); // [R15]

  apc_result_mem u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(wr_ptr),
    .wdata_i(mem_wdata),
    .raddr_i(rd_ptr),
    .rdata_o(mem_rdata)
  );

  always_comb begin
    next_state = state;
    next_conv_left = conv_left;
    next_res_cnt = res_cnt;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_res_valid = res_valid;
    next_chan = chan;
    next_conv_start_o = 1'b0;
    mem_we = 1'b0;
    next_setup = setup;
    next_config_reg = config_reg;
    next_wb_ack_o = 1'b0;
    next_wb_dat_o = wb_dat_o;
    case (state)
      apc_pkg::APC_OFF: begin
        if (addr_ok_i) begin
          next_state = apc_pkg::APC_RUN; // [R7]
          next_conv_start_o = 1'b1; // [R9]
        end
      end
      apc_pkg::APC_RUN: begin
        if (conv_done_i) begin
          mem_we = 1'b1;
          next_wr_ptr = wr_ptr + 1'b1;
          if (res_cnt != `APC_EIGHT_COUNT) begin
            next_res_cnt = res_cnt + 4'h1;
          end
          next_chan = chan_step(scan, chan, cs0);
        end
        if (clk_bus) begin
          if (end_evt) begin
            next_state = apc_pkg::APC_OFF; // [R4]
          end else if (conv_done_i) begin
            next_conv_start_o = 1'b1;
          end
        end else if (conv_done_i) begin
          next_conv_left = conv_left - 4'h1;
          if (conv_left == 4'h1) begin
            next_state = apc_pkg::APC_HOLD; // [R5]
            next_res_valid = 1'b1;
          end else begin
            next_conv_start_o = 1'b1;
          end
        end
      end
      apc_pkg::APC_HOLD: begin
        if (stop_i || rstart_i) begin
          next_state = apc_pkg::APC_OFF; // [R6]
          next_res_valid = 1'b0;
        end
        if (addr_ok_i) begin
          next_state = apc_pkg::APC_RUN; // [R7]
          next_conv_start_o = 1'b1;
        end
      end
      default: begin
        next_state = apc_pkg::APC_OFF;
      end
    endcase
    // A new address outside a run starts a fresh scan from the first memory slot.
    if (addr_ok_i && state != apc_pkg::APC_RUN) begin
      next_conv_left = scan_count(scan, cs0);
      next_chan = (scan == `APC_SCAN_UP) ? 1'b0 : cs0;
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_res_cnt = '0;
      next_res_valid = 1'b0;
    end
    if (req) begin
      next_wb_ack_o = 1'b1;
      next_wb_dat_o = '0;
      if (wb_adr_i == `APC_ADR_SETUP) begin
        next_wb_dat_o = {24'h0, setup};
        if (wb_we_i && wb_sel_i[0]) begin
          next_setup = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == `APC_ADR_CONFIG) begin
        next_wb_dat_o = {24'h0, config_reg};
        if (wb_we_i && wb_sel_i[0]) begin
          next_config_reg = wb_dat_i[7:0];
        end
      end else if (wb_adr_i == `APC_ADR_STATUS) begin
        next_wb_dat_o = {24'h0, res_valid, iref_ready_o, state, res_cnt};
      end else if (wb_adr_i == `APC_ADR_RESULT) begin
        if (!wb_we_i && res_cnt != 4'h0) begin
          next_wb_dat_o = {16'h0, `APC_RES_PAD, mem_rdata};
          next_rd_ptr = rd_step(rd_ptr, res_cnt);
        end
      end
    end
  end

  always_comb begin
    // Internal reference power follows the selection; with the low bit clear it is on only while running.
    next_iref_pwr_o = sel[2] && (sel[0] || next_state == apc_pkg::APC_RUN); // [R10] [R14] [R12]
    if (!iref_pwr_o || next_setup[`APC_SETUP_SEL_LSB +: 3] != sel) begin
      next_iref_cnt = '0;
    end else if (iref_cnt < IREF_WAKE_CYC[17:0]) begin
      next_iref_cnt = iref_cnt + 18'h1; // [R8]
    end else begin
      next_iref_cnt = iref_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= apc_pkg::APC_OFF;
      setup <= `APC_SETUP_RST; // [R1] [R16]
      config_reg <= `APC_CFG_RST; // [R1] [R17]
      conv_left <= '0;
      res_cnt <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      res_valid <= 1'b0;
      chan <= 1'b0;
      iref_cnt <= '0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      conv_start_o <= 1'b0;
      conv_chan_o <= 1'b0;
      conv_diff_o <= 1'b0;
      conv_clk_bus_o <= 1'b0;
      stretch_o <= 1'b0;
      analog_pwr_o <= 1'b0;
      iref_pwr_o <= 1'b0;
      iref_ready_o <= 1'b0;
      ref_drive_o <= 1'b0;
      ref_ext_o <= 1'b0;
      ref_src_o <= 2'h0;
    end else begin
      state <= next_state;
      setup <= next_setup;
      config_reg <= next_config_reg;
      conv_left <= next_conv_left;
      res_cnt <= next_res_cnt;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      res_valid <= next_res_valid;
      chan <= next_chan;
      iref_cnt <= next_iref_cnt;
      wb_ack_o <= next_wb_ack_o;
      wb_dat_o <= next_wb_dat_o;
      conv_start_o <= next_conv_start_o;
      conv_chan_o <= next_chan;
      conv_diff_o <= !config_reg[`APC_CFG_PAIR_BIT]; // [R17]
      conv_clk_bus_o <= clk_bus; // [R16]
      stretch_o <= (next_state == apc_pkg::APC_RUN) && !clk_bus;
      analog_pwr_o <= (next_state == apc_pkg::APC_RUN); // [R3] [R5]
      iref_pwr_o <= next_iref_pwr_o;
      iref_ready_o <= next_iref_pwr_o && (next_iref_cnt >= IREF_WAKE_CYC[17:0]); // [R8]
      // The pin only drives while awake, so it floats in shutdown.
      ref_drive_o <= (sel[2:1] == 2'h3) && (next_state == apc_pkg::APC_RUN); // [R13] [R11]
      ref_ext_o <= (sel[2:1] == 2'h1); // [R12]
      ref_src_o <= sel[2] ? 2'h2 : {1'b0, sel[1]}; // [R12] [R13]
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_reset_values: assert property ($fell(rst_i) // [R1]
    |-> setup == `APC_SETUP_RST && config_reg == `APC_CFG_RST)
    else $error("Setup or configuration wrong after reset.");
  a_idle_off: assert property (state != apc_pkg::APC_RUN // [R3]
    |-> !analog_pwr_o && !ref_drive_o)
    else $error("Analog power on while idle.");
  a_ext_stay_up: assert property (state == apc_pkg::APC_RUN && clk_bus && !end_evt // [R4]
    |=> state == apc_pkg::APC_RUN)
    else $error("External clock mode left run without bus event.");
  a_ext_end_idle: assert property (state == apc_pkg::APC_RUN && clk_bus && end_evt // [R4]
    |=> !analog_pwr_o)
    else $error("External clock mode stayed powered after end event.");
  a_int_scan_off: assert property (state == apc_pkg::APC_RUN && !clk_bus && conv_done_i // [R5]
    && conv_left == 4'h1 |=> state == apc_pkg::APC_HOLD && !analog_pwr_o && res_valid)
    else $error("Internal scan end did not power down.");
  a_hold_keep: assert property (state == apc_pkg::APC_HOLD && !stop_i && !rstart_i // [R6]
    && !addr_ok_i |=> state == apc_pkg::APC_HOLD && res_valid)
    else $error("Held results lost without STOP or restart.");
  a_wake_addr: assert property (state != apc_pkg::APC_RUN && addr_ok_i // [R7]
    |=> analog_pwr_o && conv_start_o)
    else $error("Valid address did not wake the converter.");
  a_iref_kept: assert property (sel[2] && sel[0] && $stable(setup) |=> iref_pwr_o) // [R10]
    else $error("Always-on internal reference dropped.");
  a_ref_float: assert property (ref_drive_o |-> analog_pwr_o) // [R11]
    else $error("Reference pin driven during shutdown.");
  a_ext_decode: assert property (!$past(sel[2]) // [R12]
    |-> !iref_pwr_o && ref_src_o == {1'b0, $past(sel[1])})
    else $error("Supply or external reference decode wrong.");
  a_int_decode: assert property ($past(sel[2]) |-> ref_src_o == 2'h2 && !ref_ext_o) // [R13]
    else $error("Internal reference decode wrong.");
  a_code_fmt: assert property (mem_we // [R15]
    |-> mem_wdata[`APC_RES_W-1] == (conv_data_i[`APC_RES_W-1] ^ bip))
    else $error("Result coding wrong.");
  a_bus_ack: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus acknowledge not one cycle.");

  c_ext_run_stop: cover property (state == apc_pkg::APC_RUN && clk_bus ##[1:20] stop_i);
  c_int_hold_stop: cover property (state == apc_pkg::APC_HOLD ##[1:50] stop_i);
  c_eight_scan: cover property (res_cnt == `APC_EIGHT_COUNT && state == apc_pkg::APC_HOLD);
  c_iref_ready: cover property ($rose(iref_ready_o));
endmodule

// ==== hdl/apc_result_mem.sv ====
// Result memory of the converter with a registered read port.
`timescale 1ns/10ps
`include "apc_defines.svh"
module apc_result_mem (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic we_i,
  input wire logic [`APC_MEM_AW-1:0] waddr_i,
  input wire logic [`APC_RES_W-1:0] wdata_i,
  input wire logic [`APC_MEM_AW-1:0] raddr_i,
  output logic [`APC_RES_W-1:0] rdata_o
);
  logic [`APC_RES_W-1:0] store [0:(1<<`APC_MEM_AW)-1];

  // The array has no reset; it is undefined until a conversion writes it.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      store[waddr_i] <= wdata_i; // [R2]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= store[raddr_i];
    end
  end
endmodule

// ==== shared/apc_defines.svh ====
// Constants for the converter power and reference controller.
// Function
// [R1] Reset: single-ended, unipolar, input zero, internal clock, supply.
// [R2] Result memory is not initialised at reset.
// [R3] Idle powers analog down, reference keeps policy.
// [R4] External clock: idle only after STOP, NACK, restart.
// [R5] Internal clock: power down once scan results stored.
// [R6] Internal results kept until STOP or restart.
// [R7] Idle watches bus; valid address powers up.
// [R8] Master allows reference wake time before converting.
// [R9] Supply or external reference: no extra wake delay.
// [R10] Powered reference stays on until selection rewritten.
// [R11] Reference output pin floats during shutdown.
// [R12] Top bit zero: supply or external, reference off.
// [R13] Top bit one: internal, middle bit drives pin.
// [R14] Low bit keeps internal reference always powered.
// [R15] Unipolar straight binary, bipolar two's complement.
// [R16] Clock-mode bit resets zero, one selects bus clock.
// [R17] Input pairing bit: one single-ended, resets one.
`ifndef APC_DEFINES_SVH
`define APC_DEFINES_SVH

`define APC_ADR_SETUP 8'h00
`define APC_ADR_CONFIG 8'h04
`define APC_ADR_STATUS 8'h08
`define APC_ADR_RESULT 8'h0c

`define APC_SETUP_SEL_LSB 0
`define APC_SETUP_CLK_BIT 3
`define APC_SETUP_BIP_BIT 4
`define APC_SETUP_RST 8'h00

`define APC_CFG_PAIR_BIT 0
`define APC_CFG_CS0_BIT 1
`define APC_CFG_SCAN_LSB 2
`define APC_CFG_RST 8'h01

`define APC_SCAN_UP 2'h0
`define APC_SCAN_EIGHT 2'h1
`define APC_EIGHT_COUNT 4'h8
`define APC_SINGLE_COUNT 4'h1

`define APC_RES_W 10
`define APC_MEM_AW 3
`define APC_RES_PAD 6'h3f

`define APC_CLK_HZ 25000000
`define APC_IREF_WAKE_MS 10

`endif

// ==== shared/apc_pkg.sv ====
// Types shared by the converter power and reference controller.
package apc_pkg;
  typedef enum logic [1:0] {
    APC_OFF,
    APC_RUN,
    APC_HOLD
  } apc_state_type;
endpackage

// ==== testbench/apc_conv_model.sv ====
// Behavioural converter that answers each start with one result.
`timescale 1ns/10ps
module apc_conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic slow_i,
  input wire logic conv_start_i,
  output logic conv_done_o,
  output logic [9:0] conv_data_o
);
  logic [3:0] cnt;
  logic [9:0] seq;
  logic [9:0] val;
  assign val = 10'h2a5 ^ (seq * 10'h007);
  // Outside the done pulse the bus shows the inverse, so a late sample is caught.
  assign conv_data_o = conv_done_o ? val : ~val;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 4'h0;
      seq <= 10'h000;
      conv_done_o <= 1'b0;
    end else begin
      if (conv_start_i) begin
        cnt <= slow_i ? 4'h5 : 4'h1;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
      conv_done_o <= (cnt == 4'h1) && !conv_start_i;
      if (conv_done_o) begin
        seq <= seq + 10'h001;
      end
    end
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking bench for the power and reference controller.
`timescale 1ns/10ps
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [3:0] ev = 4'h0;
  logic slow = 1'b0;
  logic [31:0] dat_o;
  logic [31:0] q;
  logic [9:0] cdata;
  logic [1:0] rsrc;
  logic [2:0] v;
  logic ack, done, start, chan, diff, cbus, str, apwr, ipwr, irdy, rdrv, rext;
  int fail_count = 0;
  int compares = 0;
  always #20 clk_i = ~clk_i;
  apc_power_ctrl #(.IREF_WAKE_CYC(20)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .addr_ok_i(ev[0]),
    .stop_i(ev[1]), .nack_i(ev[2]), .rstart_i(ev[3]), .conv_done_i(done),
    .conv_data_i(cdata), .conv_start_o(start), .conv_chan_o(chan), .conv_diff_o(diff),
    .conv_clk_bus_o(cbus), .stretch_o(str), .analog_pwr_o(apwr), .iref_pwr_o(ipwr),
    .iref_ready_o(irdy), .ref_drive_o(rdrv), .ref_ext_o(rext), .ref_src_o(rsrc));
  apc_conv_model u_conv (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow),
    .conv_start_i(start), .conv_done_o(done), .conv_data_o(cdata));
  task automatic tally_and_finish();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic fail_out();
    fail_count++;
    tally_and_finish();
  endtask
  // The request is held until ack is sampled, then dropped for one idle cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h1;
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) fail_out();
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic ev_pulse(input logic [3:0] e);
    ev <= e;
    @(posedge clk_i);
    ev <= 4'h0;
  endtask
  task automatic wait_pwr(input logic lvl);
    int n;
    n = 0;
    while (apwr !== lvl) begin
      @(posedge clk_i);
      n++;
      if (n > 500) fail_out();
    end
  endtask
  task automatic scan();
    ev_pulse(4'h1);
    @(posedge clk_i);
    chk({start, apwr, str, chan}, 4'he);
    wait_pwr(1'b0);
  endtask
  function automatic logic [31:0] res(input int n, input logic bip);
    logic [9:0] r;
    r = 10'h2a5 ^ (n[9:0] * 10'h007);
    r[9] = r[9] ^ bip;
    return {16'h0, 6'h3f, r};
  endfunction
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 8'h00, 0);
    chk(q, 32'h0);
    bus(0, 8'h04, 0);
    chk(q, 32'h1);
    chk({diff, cbus, rsrc, apwr, ipwr}, 6'h0);
    bus(0, 8'h10, 0);
    chk(q, 32'h0);
    $display("test defaults done");
    scan();
    bus(0, 8'h08, 0);
    chk(q, 32'ha1);
    for (int i = 0; i < 2; i++) begin
      bus(0, 8'h0c, 0);
      chk(q, res(0, 0));
    end
    ev_pulse(4'h2);
    bus(0, 8'h08, 0);
    chk(q[7], 1'b0);
    $display("test single scan done");
    slow <= 1'b1;
    bus(1, 8'h04, 32'h5);
    scan();
    bus(0, 8'h08, 0);
    chk(q, 32'ha8);
    for (int i = 0; i < 9; i++) begin
      bus(0, 8'h0c, 0);
      chk(q, res(1 + i % 8, 0));
    end
    ev_pulse(4'h8);
    $display("test eight scan done");
    bus(1, 8'h00, 32'h10);
    bus(1, 8'h04, 32'h1);
    scan();
    bus(0, 8'h0c, 0);
    chk(q, res(9, 1));
    ev_pulse(4'h2);
    $display("test bipolar done");
    bus(1, 8'h00, 32'h08);
    @(posedge clk_i);
    chk(cbus, 1'b1);
    for (int i = 1; i < 4; i++) begin
      ev_pulse(4'h1);
      repeat (30) @(posedge clk_i);
      chk(apwr, 1'b1);
      ev_pulse(4'h1 << i);
      @(posedge clk_i);
      chk(apwr, 1'b0);
      repeat (8) @(posedge clk_i);
    end
    $display("test external clock done");
    for (int s = 0; s < 8; s++) begin
      v = s[2:0];
      bus(1, 8'h00, {29'h0, v});
      @(posedge clk_i);
      chk({rsrc, rext, ipwr, rdrv},
          {v[2] ? 2'h2 : {1'b0, v[1]}, ~v[2] & v[1], v[2] & v[0], 1'b0});
    end
    $display("test reference decode done");
    bus(1, 8'h00, 32'h04);
    bus(1, 8'h00, 32'h07);
    repeat (18) @(posedge clk_i);
    chk(irdy, 1'b0);
    repeat (6) @(posedge clk_i);
    chk(irdy, 1'b1);
    bus(1, 8'h00, 32'h07);
    @(posedge clk_i);
    chk(ipwr, 1'b1);
    ev_pulse(4'h1);
    @(posedge clk_i);
    chk(rdrv, 1'b1);
    wait_pwr(1'b0);
    @(posedge clk_i);
    chk({rdrv, ipwr}, 2'h1);
    $display("test internal reference done");
    tally_and_finish();
  end
endmodule
